// file: bench/test_compact_timer_enable_period.sv
// Self-checking bench for the timer run control and period compare
`timescale 1ns/1ps

module test_compact_timer_enable_period;
  logic mclk_i;
  logic rst_b_i;
  logic wr_i;
  logic rd_i;
  logic ext_clk_i;
  logic [3:0] addr_i;
  logic [7:0] wdata_i;
  logic [7:0] rdata_o;
  logic out_pin_o;
  logic out_pin_n_o;
  logic irq_o;
  int failures;
  int cmp_count;

  ctep_timer dut
  (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .ext_clk_i(ext_clk_i),
    .out_pin_o(out_pin_o),
    .out_pin_n_o(out_pin_n_o),
    .irq_o(irq_o)
  );

  initial
  begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  // ****
  // Shared tasks
  // ****
  task automatic tally_and_finish;
    $display("Mismatches %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [9:0] e,
                     input logic [9:0] g);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  // High byte first so the low byte is latched with it
  task automatic rd_cnt(output logic [9:0] c);
    logic [7:0] h;
    logic [7:0] l;
    rd(4'h3, h);
    rd(4'h2, l);
    c = {h[1:0], l};
  endtask

  task automatic settle;
    @(posedge mclk_i);
    #1;
  endtask

  // ****
  // Scenarios
  // ****
  task automatic sc_reset;
    logic [7:0] d;
    wr(4'h9, 8'hff);
    for (int i = 0; i < 10; i++)
    begin
      rd(i[3:0], d);
      chk("reg after reset", 10'h000, {2'h0, d});
    end
    chk("irq after reset", 10'h000, {9'h0, irq_o});
  endtask

  task automatic sc_run;
    logic [9:0] c1;
    logic [9:0] c2;
    wr(4'h1, 8'hc0);
    wr(4'h0, 8'h08);
    repeat (50) @(posedge mclk_i);
    wr(4'h0, 8'h00);
    rd_cnt(c1);
    chk("count ran", 10'h001, {9'h0, c1 > 10'd40 && c1 < 10'd60});
    repeat (20) @(posedge mclk_i);
    rd_cnt(c2);
    chk("count frozen", c1, c2);
    wr(4'h0, 8'h08);
    wr(4'h0, 8'h00);
    rd_cnt(c2);
    chk("count cleared", 10'h001, {9'h0, c2 < 10'd8});
  endtask

  task automatic sc_period(input logic [2:0] p);
    logic [7:0] s;
    logic [9:0] c;
    int n;
    n = (p == 3'h0) ? 1024 : p * 128;
    wr(4'h1, 8'hc0);
    wr(4'h6, 8'h07);
    wr(4'h0, {4'h0, 1'b1, p});
    repeat (n - 12) @(posedge mclk_i);
    rd(4'h6, s);
    chk("no early match", 10'h000, {8'h0, s[2], s[0]});
    repeat (24) @(posedge mclk_i);
    rd(4'h6, s);
    chk("period match", {9'h0, p != 3'h0}, {9'h0, s[0]});
    chk("overflow", {9'h0, p == 3'h0}, {9'h0, s[2]});
    wr(4'h0, {4'h0, 1'b0, p});
    rd_cnt(c);
    chk("count wrapped", 10'h001, {9'h0, c < 10'd40});
  endtask

  task automatic sc_cclr;
    logic [9:0] c;
    wr(4'h4, 8'hff);
    wr(4'h5, 8'h03);
    wr(4'h1, 8'hc1);
    wr(4'h0, 8'h09);
    repeat (300) @(posedge mclk_i);
    wr(4'h0, 8'h01);
    rd_cnt(c);
    chk("count past match", 10'h001, {9'h0, c > 10'd280});
  endtask

  task automatic sc_pin;
    wr(4'h0, 8'h00);
    wr(4'h4, 8'h0a);
    wr(4'h5, 8'h00);
    wr(4'h1, 8'h38);
    wr(4'h0, 8'h0f);
    settle();
    chk("pin initial", 10'h001, {9'h0, out_pin_o});
    repeat (30) @(posedge mclk_i);
    #1;
    chk("pin toggled", 10'h000, {9'h0, out_pin_o});
    chk("pin pair same", {9'h0, out_pin_o}, {9'h0, out_pin_n_o});
    wr(4'h0, 8'h07);
    wr(4'h0, 8'h0f);
    settle();
    chk("pin restored", 10'h001, {9'h0, out_pin_o});
    wr(4'h1, 8'h3a);
    settle();
    chk("pin pair inverse", {9'h0, ~out_pin_o}, {9'h0, out_pin_n_o});
    wr(4'h1, 8'hc8);
    settle();
    chk("pin timer mode", 10'h000, {9'h0, out_pin_o});
  endtask

  task automatic sc_irq;
    wr(4'h0, 8'h00);
    wr(4'h1, 8'hc0);
    wr(4'h6, 8'h07);
    wr(4'h7, 8'h01);
    wr(4'h0, 8'h09);
    repeat (140) @(posedge mclk_i);
    wr(4'h0, 8'h01);
    settle();
    chk("irq raised", 10'h001, {9'h0, irq_o});
    wr(4'h7, 8'h00);
    settle();
    chk("irq masked", 10'h000, {9'h0, irq_o});
    wr(4'h7, 8'h01);
    wr(4'h6, 8'h01);
    settle();
    chk("irq cleared", 10'h000, {9'h0, irq_o});
  endtask

  initial
  begin
    repeat (100000) @(posedge mclk_i);
    failures++;
    $display("Error watchdog expected end seen hang");
    tally_and_finish();
  end

  initial
  begin
    failures = 0;
    cmp_count = 0;
    rst_b_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    ext_clk_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 8'h00;
    repeat (20) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    sc_reset();
    sc_run();
    for (int p = 0; p < 8; p++)
      sc_period(p[2:0]);
    sc_cclr();
    sc_pin();
    sc_irq();
    tally_and_finish();
  end
endmodule

// file: common/ctep_defines.svh
// Register offsets, field positions, reset values and timing counts
`ifndef CTEP_DEFINES_SVH
`define CTEP_DEFINES_SVH

`define CTEP_ADDR_CTRL0 4'h0
`define CTEP_ADDR_CTRL1 4'h1
`define CTEP_ADDR_CNTL 4'h2
`define CTEP_ADDR_CNTH 4'h3
`define CTEP_ADDR_CMPL 4'h4
`define CTEP_ADDR_CMPH 4'h5
`define CTEP_ADDR_STAT 4'h6
`define CTEP_ADDR_MASK 4'h7

`define CTEP_C0_RUN 3
`define CTEP_C1_CCLR 0
`define CTEP_C1_OINIT 3
`define CTEP_C1_POL 2
`define CTEP_C1_DPX 1

`define CTEP_CTRL_RST 8'h00
`define CTEP_PERIOD_STEP 11'h080
`define CTEP_PERIOD_ZERO 11'h400

`define CTEP_ST_PMATCH 0
`define CTEP_ST_AMATCH 1
`define CTEP_ST_OVF 2

`endif

// file: common/ctep_pkg.sv
// Types shared by the timer design files
package ctep_pkg;

  typedef enum logic [1:0]
  {
    CTEP_MODE_CMP = 2'h0,
    CTEP_MODE_UNDEF = 2'h1,
    CTEP_MODE_PWM = 2'h2,
    CTEP_MODE_TMR = 2'h3
  } ctep_mode_e;

  typedef struct packed
  {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } ctep_bus_s;

  typedef struct packed
  {
    logic pmatch;
    logic amatch;
    logic ovf;
  } ctep_evt_s;

endpackage

// file: design/ctep_sync3.sv
// Three-stage synchroniser for the external count pin
`timescale 1ns/1ps
`include "ctep_defines.svh"

module ctep_sync3
  import ctep_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Pin in, filtered level out
  input wire logic pin_i,
  output logic level_o
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;
  wire agree = (s2_q == s3_q);

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
    end
    else
    begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (agree)
        level_q <= s3_q;
    end
  end

  assign level_o = level_q;

endmodule

// file: design/ctep_timer.sv
// Compact 10-bit timer: run control, period compare, output and registers
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "ctep_defines.svh"

module ctep_timer
  import ctep_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // External count pin
  input wire logic ext_clk_i,
  // Timer output pins
  output logic out_pin_o,
  output logic out_pin_n_o,
  output logic irq_o
);

  // ****************************************
  // Register port
  // ****************************************
  ctep_bus_s bus;
  assign bus = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};

  logic [7:0] ctrl0_q;
  logic [7:0] ctrl1_q;
  logic [9:0] cmpa_q;
  logic [7:0] cmpa_lo_buf_q;
  logic [7:0] cnt_lo_buf_q;
  logic [2:0] stat_q;
  logic [2:0] mask_q;
  logic [7:0] rdata_q;
  logic [9:0] cnt_q;
  logic [9:0] cnt_d;
  logic run_q;
  logic out_q;
  logic ext_prev_q;

  wire sel_c0 = (bus.addr == `CTEP_ADDR_CTRL0);
  wire sel_c1 = (bus.addr == `CTEP_ADDR_CTRL1);
  wire sel_dl = (bus.addr == `CTEP_ADDR_CNTL);
  wire sel_dh = (bus.addr == `CTEP_ADDR_CNTH);
  wire sel_al = (bus.addr == `CTEP_ADDR_CMPL);
  wire sel_ah = (bus.addr == `CTEP_ADDR_CMPH);
  wire sel_st = (bus.addr == `CTEP_ADDR_STAT);
  wire sel_mk = (bus.addr == `CTEP_ADDR_MASK);

  logic [7:0] rd_mux;
  always_comb
  begin
    if (sel_c0)
      rd_mux = ctrl0_q;
    else if (sel_c1)
      rd_mux = ctrl1_q;
    else if (sel_dl)
      rd_mux = cnt_lo_buf_q;
    else if (sel_dh)
      rd_mux = {6'h00, cnt_q[9:8]};
    else if (sel_al)
      rd_mux = cmpa_q[7:0];
    else if (sel_ah)
      rd_mux = {6'h00, cmpa_q[9:8]};
    else if (sel_st)
      rd_mux = {5'h00, stat_q};
    else if (sel_mk)
      rd_mux = {5'h00, mask_q};
    else
      rd_mux = 8'h00;
  end

  // ****************************************
  // Control fields
  // ****************************************
  wire run_en = ctrl0_q[`CTEP_C0_RUN];
  wire pause = ctrl0_q[7];
  wire [2:0] clk_sel = ctrl0_q[6:4];
  wire [2:0] period_match_bits = ctrl0_q[2:0];
  ctep_mode_e mode;
  assign mode = ctep_mode_e'(ctrl1_q[7:6]);
  wire [1:0] out_func = ctrl1_q[5:4];
  wire out_init = ctrl1_q[`CTEP_C1_OINIT];
  wire out_pol = ctrl1_q[`CTEP_C1_POL];
  wire dual_sel = ctrl1_q[`CTEP_C1_DPX];
  wire clr_sel = ctrl1_q[`CTEP_C1_CCLR];

  wire run_rise = run_en && !run_q;

  // ****************************************
  // Counter clock tick
  // ****************************************
  // Only the system clock and the pin are modelled as sources; code 5 gives
  // no tick, and the divided clocks fall back to the system clock to keep the block small.
  logic ext_lvl;
  ctep_sync3 u_sync
  (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .pin_i(ext_clk_i),
    .level_o(ext_lvl)
  );
  wire ext_rise = ext_lvl && !ext_prev_q;
  wire ext_fall = !ext_lvl && ext_prev_q;
  wire tick_src = (clk_sel == 3'h6) ? ext_rise :
                  (clk_sel == 3'h7) ? ext_fall :
                  (clk_sel == 3'h5) ? 1'b0 : 1'b1;
  wire tick = run_en && !run_rise && !pause && tick_src;

  // ****************************************
  // Period and compare matches
  // ****************************************
  // The period bits see only counter bits 9..7, so a match arrives after
  // n*128 clocks; code 000 never matches, and the count runs on until it wraps.
  wire [2:0] cnt_top = cnt_q[9:7];
  wire pmatch_raw = (period_match_bits != 3'h0) &&
                    (cnt_top == period_match_bits) &&
                    (cnt_q[6:0] == 7'h00);
  wire at_max = (cnt_q == 10'h3ff);
  wire ovf = tick && at_max;
  wire pmatch = tick && ((cnt_q + 10'h001) == {period_match_bits, 7'h00})
                && (period_match_bits != 3'h0);
  wire amatch = tick && ((cnt_q + 10'h001) == cmpa_q);
  wire pm_clear = pmatch && !clr_sel;
  wire am_clear = amatch && clr_sel;

  always_comb
  begin
    cnt_d = cnt_q;
    if (run_rise)
      cnt_d = 10'h000;
    else if (!run_en)
      cnt_d = cnt_q;
    else if (pm_clear || am_clear || ovf)
      cnt_d = 10'h000;
    else if (tick)
      cnt_d = cnt_q + 10'h001;
  end

  // ****************************************
  // Output pin
  // ****************************************
  // Compare output mode acts on compare A only; the period match just clears the count, and only when clr_sel is 0
  wire cmp_event = amatch;
  logic out_d;
  always_comb
  begin
    out_d = out_q;
    if (mode == CTEP_MODE_CMP)
    begin
      if (run_rise)
        out_d = out_init;
      else if (cmp_event)
      begin
        case (out_func)
          2'h1: out_d = 1'b0;
          2'h2: out_d = 1'b1;
          2'h3: out_d = !out_q;
          default: out_d = out_q;
        endcase
      end
    end
    else if (mode == CTEP_MODE_PWM)
    begin
      if (pmatch || ovf)
        out_d = 1'b1;
      else if (amatch)
        out_d = 1'b0;
    end
  end

  wire out_lvl = out_pol ? !out_q : out_q;
  assign out_pin_o = (mode == CTEP_MODE_TMR) ? 1'b0 : out_lvl;
  assign out_pin_n_o = dual_sel ? !out_pin_o : out_pin_o;

  // ****************************************
  // Events and interrupt
  // ****************************************
  ctep_evt_s evt;
  assign evt = '{pmatch: pmatch, amatch: amatch, ovf: ovf};
  wire [2:0] evt_v = {evt.ovf, evt.amatch, evt.pmatch};
  wire [2:0] st_clr = (bus.wr && sel_st) ? bus.wdata[2:0] : 3'h0;
  // A new event wins over a same-cycle write-one clear
  wire [2:0] stat_d = (stat_q & ~st_clr) | evt_v;
  assign irq_o = |(stat_q & mask_q);

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ctrl0_q <= `CTEP_CTRL_RST;
      ctrl1_q <= `CTEP_CTRL_RST;
      cmpa_q <= 10'h000;
      cmpa_lo_buf_q <= 8'h00;
      cnt_lo_buf_q <= 8'h00;
      stat_q <= 3'h0;
      mask_q <= 3'h0;
      rdata_q <= 8'h00;
      cnt_q <= 10'h000;
      run_q <= 1'b0;
      out_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end
    else
    begin
      if (bus.wr && sel_c0)
        ctrl0_q <= bus.wdata;
      if (bus.wr && sel_c1)
        ctrl1_q <= bus.wdata;
      if (bus.wr && sel_al)
        cmpa_lo_buf_q <= bus.wdata;
      if (bus.wr && sel_ah)
        cmpa_q <= {bus.wdata[1:0], cmpa_lo_buf_q};
      if (bus.rd && sel_dh)
        cnt_lo_buf_q <= cnt_q[7:0];
      if (bus.wr && sel_mk)
        mask_q <= bus.wdata[2:0];
      stat_q <= stat_d;
      rdata_q <= bus.rd ? rd_mux : 8'h00;
      cnt_q <= cnt_d;
      run_q <= run_en;
      out_q <= out_d;
      ext_prev_q <= ext_lvl;
    end
  end

  assign rdata_o = rdata_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_run_clear_cnt: assert property (
    $rose(run_en) |=> (cnt_q == 10'h000))
    else $error("counter not cleared on enable");
  a_stop_hold_cnt: assert property (
    !run_en && !$rose(run_en) |=> $stable(cnt_q))
    else $error("counter moved while off");
  a_off_no_count: assert property (
    !run_en |-> !tick)
    else $error("tick while off");
  a_init_out_level: assert property (
    $rose(run_en) && mode == CTEP_MODE_CMP |=> out_q == $past(out_init))
    else $error("output not reset to initial level");
  a_period_match_pos: assert property (
    pmatch |-> (cnt_top + 3'h1 == period_match_bits && cnt_q[6:0] == 7'h7f))
    else $error("period match at wrong count");
  a_period_clr_zero: assert property (
    pmatch && !clr_sel && run_en && !run_rise |=> cnt_q == 10'h000)
    else $error("period match did not clear");
  a_keep_on_sel: assert property (
    pmatch && clr_sel && !amatch && !ovf |=> cnt_q == $past(cnt_q) + 10'h001)
    else $error("period match cleared with select set");
  a_wrap_at_max: assert property (
    ovf |=> cnt_q == 10'h000)
    else $error("no wrap at maximum");
  a_count_step: assert property (
    tick && !ovf && !pmatch && !amatch |=> cnt_q == $past(cnt_q) + 10'h001)
    else $error("counter did not step");
  a_period_code_zero: assert property (
    period_match_bits == 3'h0 |-> !pmatch)
    else $error("code zero matched early");

  c_enable_rise: cover property ($rose(run_en));
  c_period_clear: cover property (pm_clear);
  c_overflow: cover property (ovf);
  c_period_top: cover property (pmatch_raw && run_en);
  c_irq: cover property ($rose(irq_o));

endmodule
